// ===== rtl/flash_host_pkg.sv
`default_nettype none
package flash_host_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS    = 8;
    localparam int WE_LOW_NS        = 40;
    localparam int WE_LOW_CYC       =
        (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RD_LOW_NS        = 80;
    localparam int RD_LOW_CYC       =
        (RD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCEPT_WINDOW_NS = 50000;
    localparam int ACCEPT_CYC       = ACCEPT_WINDOW_NS / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////
    // Controller registers (byte offsets)
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_DATA   = 8'h08;
    localparam logic [7:0] REG_RDATA  = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_HWRST  = 8'h14;

    localparam int ST_BUSY_BIT   = 0;
    localparam int ST_LATE_BIT   = 1;
    localparam int ST_WINDOW_BIT = 2;
    localparam int ST_TOGGLE_BIT = 7;
    localparam int ST_HWRST_BIT  = 8;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Flash command words
    localparam logic [21:0] ADDR_UNLOCK1 = 22'h000555;
    localparam logic [21:0] ADDR_UNLOCK2 = 22'h0002AA;
    localparam logic [21:0] ADDR_ANY     = 22'h000000;
    localparam logic [15:0] CMD_UNLOCK1  = 16'h00AA;
    localparam logic [15:0] CMD_UNLOCK2  = 16'h0055;
    localparam logic [15:0] CMD_SETUP    = 16'h0080;
    localparam logic [15:0] CMD_CONFIRM  = 16'h0030;
    localparam logic [15:0] CMD_SUSPEND  = 16'h00B0;
    localparam logic [15:0] CMD_RESET    = 16'h00F0;
    localparam logic [15:0] CMD_IDENT    = 16'h0090;
    localparam logic [15:0] CMD_SECURE   = 16'h0088;
    localparam logic [15:0] CMD_ZERO     = 16'h0000;
    localparam logic [15:0] CMD_BUFLOAD  = 16'h0025;
    localparam logic [15:0] CMD_BUFGO    = 16'h0029;
    localparam logic [15:0] CMD_BYPASS   = 16'h0020;
    localparam logic [15:0] CMD_PROGRAM  = 16'h00A0;

    typedef enum logic [4:0] {
        OP_READ      = 5'h00, OP_RESET     = 5'h01,
        OP_ERASE     = 5'h02, OP_ADD_SECT  = 5'h03,
        OP_SUSPEND   = 5'h04, OP_RESUME    = 5'h05,
        OP_IDENT     = 5'h06, OP_SEC_ENTER = 5'h07,
        OP_SEC_EXIT  = 5'h08, OP_BUF_START = 5'h09,
        OP_BUF_LOAD  = 5'h0A, OP_BUF_GO    = 5'h0B,
        OP_ABORT_RST = 5'h0C, OP_BYP_ENTER = 5'h0D,
        OP_BYP_PROG  = 5'h0E, OP_BYP_EXIT  = 5'h0F,
        OP_PROGRAM   = 5'h10
    } op_t;
    localparam logic [4:0] OP_LAST = 5'h10;

    typedef struct packed {
        logic [21:0] addr;
        logic [15:0] data;
    } bus_word_t;

    typedef struct packed {
        logic [21:0] addr;
        logic [15:0] dq_out;
        logic        dq_oe;
        logic        chip_select_n;
        logic        write_strobe_n;
        logic        output_enable_n;
        logic        reset_n;
        logic        width_select_n;
    } flash_pins_t;

endpackage
`default_nettype wire

// ===== rtl/flash_bus_cycle.sv
`timescale 1ns/100ps
`default_nettype none
module flash_bus_cycle
    import flash_host_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        start,
    input  wire logic        is_write,
    input  wire bus_word_t   req,
    input  wire logic [15:0] dq_in,
    output logic             done,
    output logic [15:0]      rd_data,
    output flash_pins_t      pins
);

    typedef enum logic [1:0] {
        PH_IDLE   = 2'b00,
        PH_SETUP  = 2'b01,
        PH_STROBE = 2'b10,
        PH_HOLD   = 2'b11
    } phase_t;

    phase_t     ph_r;
    logic [3:0] cnt_r;
    logic       wr_r;

    wire [3:0] strobe_len = wr_r ? 4'(WE_LOW_CYC) : 4'(RD_LOW_CYC);
    wire       last       = (cnt_r == strobe_len - 4'h1);

    ////////////////////////////////////////////////////////////////////////
    // Address set up one cycle before the strobe falls
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ph_r    <= PH_IDLE;
            cnt_r   <= 4'h0;
            wr_r    <= 1'b0;
            done    <= 1'b0;
            rd_data <= 16'h0000;
            pins    <= '{22'h000000, 16'h0000, 1'b0, 1'b1, 1'b1, 1'b1,
                         1'b1, 1'b1};
        end else begin
            done <= 1'b0;
            case (ph_r)
                PH_IDLE: if (start) begin
                    ph_r               <= PH_SETUP;
                    wr_r               <= is_write;
                    pins.addr          <= req.addr;
                    pins.dq_out        <= req.data;
                    pins.dq_oe         <= is_write;
                    pins.chip_select_n <= 1'b0;
                end
                PH_SETUP: begin
                    ph_r                 <= PH_STROBE;
                    cnt_r                <= 4'h0;
                    pins.write_strobe_n  <= ~wr_r;
                    pins.output_enable_n <= wr_r;
                end
                PH_STROBE: begin
                    cnt_r <= cnt_r + 4'h1;
                    if (last) begin
                        ph_r                 <= PH_HOLD;
                        pins.write_strobe_n  <= 1'b1;
                        pins.output_enable_n <= 1'b1;
                        if (!wr_r) rd_data <= dq_in;
                    end
                end
                PH_HOLD: begin
                    ph_r               <= PH_IDLE;
                    pins.chip_select_n <= 1'b1;
                    pins.dq_oe         <= 1'b0;
                    done               <= 1'b1;
                end
                default: ph_r <= PH_IDLE;
            endcase
        end
    end

    a_we_pulse_width: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $fell(pins.write_strobe_n) |->
            (!pins.write_strobe_n && pins.dq_oe)[*5]
            ##1 (pins.write_strobe_n && pins.dq_oe))
        else $error("write strobe low time or data hold wrong");

endmodule
`default_nettype wire

// ===== rtl/flash_host_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Sector erase is six writes, 80 then 30.
// - Host spaces added sectors under 50 us; a late add is still issued and only sets the late flag.
// - Hardware reset aborts erase; software must restart it.
// - Ident entry unlocks then 90; offset 02 protect.
// - Secure enter ends 88; exit 90 then 00.
// - Buffer write: 25, count, pairs, then 29.
// - Aborted buffer needs three-write F0 reset.
// - Bypass entry 20; then A0 plus pair.
// - Bypass exit is 90 then 00.
module flash_host_ctrl
    import flash_host_pkg::*;
#(
    parameter int ACCEPT_CYC_P = ACCEPT_CYC
)(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic [15:0] dq_in,
    output flash_pins_t      flash_o
);

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ISSUE = 2'b01,
        ST_WAIT  = 2'b10
    } state_t;

    state_t      st_r;
    op_t         op_r;
    logic [2:0]  step_r;
    logic [21:0] addr_r;
    logic [15:0] data_r;
    logic [15:0] rd_r;
    logic        prev_tog_r;
    logic        late_r;
    logic        hwrst_r;
    logic [15:0] gap_r;
    logic [31:0] rmux;
    logic        eng_done;
    logic [15:0] eng_rd;
    bus_word_t   eng_req;
    flash_pins_t eng_pins;

    ////////////////////////////////////////////////////////////////////////
    // Command sequence tables
    function automatic logic [2:0] seq_len(op_t op);
        case (op)
            OP_ERASE:                                  return 3'd6;
            OP_IDENT, OP_SEC_ENTER, OP_ABORT_RST,
            OP_BYP_ENTER:                              return 3'd3;
            OP_SEC_EXIT, OP_BUF_START, OP_PROGRAM:     return 3'd4;
            OP_BYP_PROG, OP_BYP_EXIT:                  return 3'd2;
            default:                                   return 3'd1;
        endcase
    endfunction

    function automatic bus_word_t seq_word(op_t op, logic [2:0] s,
                                           logic [21:0] a,
                                           logic [15:0] d);
        logic unl;
        logic second;
        unl    = op inside {OP_ERASE, OP_IDENT, OP_SEC_ENTER, OP_SEC_EXIT,
                            OP_BUF_START, OP_ABORT_RST, OP_BYP_ENTER,
                            OP_PROGRAM};
        second = (op == OP_ERASE) && (s == 3'd3 || s == 3'd4);
        if (unl && (s == 3'd0 || (second && s == 3'd3)))
            return '{ADDR_UNLOCK1, CMD_UNLOCK1};
        if (unl && (s == 3'd1 || (second && s == 3'd4)))
            return '{ADDR_UNLOCK2, CMD_UNLOCK2};
        case (op)
            OP_READ:      return '{a, CMD_ZERO};
            OP_RESET:     return '{ADDR_ANY, CMD_RESET};
            OP_ERASE:     return (s == 3'd2) ? '{ADDR_UNLOCK1, CMD_SETUP}
                                             : '{a, CMD_CONFIRM};
            OP_ADD_SECT:  return '{a, CMD_CONFIRM};
            OP_SUSPEND:   return '{ADDR_ANY, CMD_SUSPEND};
            OP_RESUME:    return '{ADDR_ANY, CMD_CONFIRM};
            OP_IDENT:     return '{ADDR_UNLOCK1, CMD_IDENT};
            OP_SEC_ENTER: return '{ADDR_UNLOCK1, CMD_SECURE};
            OP_SEC_EXIT:  return (s == 3'd2) ? '{ADDR_UNLOCK1, CMD_IDENT}
                                             : '{ADDR_ANY, CMD_ZERO};
            OP_BUF_START: return (s == 3'd2) ? '{a, CMD_BUFLOAD}
                                             : '{a, d};
            OP_BUF_LOAD:  return '{a, d};
            OP_BUF_GO:    return '{a, CMD_BUFGO};
            OP_ABORT_RST: return '{ADDR_UNLOCK1, CMD_RESET};
            OP_BYP_ENTER: return '{ADDR_UNLOCK1, CMD_BYPASS};
            OP_BYP_PROG:  return (s == 3'd0) ? '{ADDR_ANY, CMD_PROGRAM}
                                             : '{a, d};
            OP_BYP_EXIT:  return (s == 3'd0) ? '{ADDR_ANY, CMD_IDENT}
                                             : '{ADDR_ANY, CMD_ZERO};
            OP_PROGRAM:   return (s == 3'd2) ? '{ADDR_UNLOCK1, CMD_PROGRAM}
                                             : '{a, d};
            default:      return '{ADDR_ANY, CMD_RESET};
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register bus decode
    wire wr_go    = awvalid && wvalid && !bvalid;
    wire wr_lane  = wr_go && wstrb[0];
    wire wr_ctrl  = (awaddr == REG_CTRL);
    wire wr_addr  = (awaddr == REG_ADDR);
    wire wr_data  = (awaddr == REG_DATA);
    wire wr_stat  = (awaddr == REG_STATUS);
    wire wr_hwrst = (awaddr == REG_HWRST);
    wire wr_map   = wr_ctrl || wr_addr || wr_data || wr_stat || wr_hwrst
                    || (awaddr == REG_RDATA);
    wire rd_go    = arvalid && !rvalid;
    wire rd_map   = (araddr == REG_CTRL) || (araddr == REG_ADDR)
                    || (araddr == REG_DATA) || (araddr == REG_RDATA)
                    || (araddr == REG_STATUS) || (araddr == REG_HWRST);

    assign awready = wr_go;
    assign wready  = wr_go;
    assign arready = rd_go;

    // Start refused while busy, in hardware reset or with unknown op
    wire go = wr_lane && wr_ctrl && st_r == ST_IDLE && !hwrst_r
              && wdata[4:0] <= OP_LAST;
    wire window_open = !hwrst_r && gap_r < 16'(ACCEPT_CYC_P);
    wire late_set    = go && op_t'(wdata[4:0]) == OP_ADD_SECT
                       && !window_open;
    wire last_step   = step_r == seq_len(op_r) - 3'd1;
    wire confirm_wr  = eng_done && (op_r == OP_ADD_SECT
                       || (op_r == OP_ERASE && last_step));
    wire [15:0] status = {7'h00, hwrst_r, rd_r[6] ^ prev_tog_r,
                          rd_r[2], rd_r[6], rd_r[7], rd_r[3],
                          window_open, late_r, st_r != ST_IDLE};

    always_comb begin
        if (araddr == REG_CTRL)
            rmux = {27'h0000000, op_r};
        else if (araddr == REG_ADDR)
            rmux = {10'h000, addr_r};
        else if (araddr == REG_DATA)
            rmux = {16'h0000, data_r};
        else if (araddr == REG_RDATA)
            rmux = {16'h0000, rd_r};
        else if (araddr == REG_STATUS)
            rmux = {16'h0000, status};
        else if (araddr == REG_HWRST)
            rmux = {31'h00000000, hwrst_r};
        else
            rmux = 32'h00000000;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid <= 1'b1;
            bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h00000000;
            rresp  <= RESP_OKAY;
        end else if (rd_go) begin
            rvalid <= 1'b1;
            rdata  <= rmux;
            rresp  <= rd_map ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_r  <= 22'h000000;
            data_r  <= 16'h0000;
            hwrst_r <= 1'b0;
            late_r  <= 1'b0;
        end else begin
            if (wr_lane && wr_addr) addr_r <= wdata[21:0];
            if (wr_lane && wr_data) data_r <= wdata[15:0];
            if (wr_lane && wr_hwrst) hwrst_r <= wdata[0];
            if (late_set)
                late_r <= 1'b1;
            else if (wr_lane && wr_stat && wdata[ST_LATE_BIT])
                late_r <= 1'b0;
        end
    end

    // Time since the last erase confirm write
    always_ff @(posedge aclk) begin
        if (!aresetn || hwrst_r)
            gap_r <= 16'hFFFF;
        else if (confirm_wr)
            gap_r <= 16'h0000;
        else if (eng_done && op_r == OP_SUSPEND)
            gap_r <= 16'hFFFF;
        else if (gap_r != 16'hFFFF)
            gap_r <= gap_r + 16'h0001;
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: one bus cycle per step
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r       <= ST_IDLE;
            op_r       <= OP_READ;
            step_r     <= 3'd0;
            rd_r       <= 16'h0000;
            prev_tog_r <= 1'b0;
        end else begin
            case (st_r)
                ST_IDLE: if (go) begin
                    st_r   <= ST_ISSUE;
                    op_r   <= op_t'(wdata[4:0]);
                    step_r <= 3'd0;
                end
                ST_ISSUE: st_r <= ST_WAIT;
                ST_WAIT: if (eng_done) begin
                    if (op_r == OP_READ) begin
                        rd_r       <= eng_rd;
                        prev_tog_r <= rd_r[6];
                    end
                    if (last_step) begin
                        st_r <= ST_IDLE;
                    end else begin
                        st_r   <= ST_ISSUE;
                        step_r <= step_r + 3'd1;
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    assign eng_req = seq_word(op_r, step_r, addr_r, data_r);

    flash_bus_cycle u_bus (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .start    (st_r == ST_ISSUE),
        .is_write (op_r != OP_READ),
        .req      (eng_req),
        .dq_in    (dq_in),
        .done     (eng_done),
        .rd_data  (eng_rd),
        .pins     (eng_pins)
    );

    always_comb begin
        flash_o                = eng_pins;
        flash_o.reset_n        = ~hwrst_r;
        flash_o.width_select_n = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic we_prev_r;
    always_ff @(posedge aclk) we_prev_r <= !aresetn || flash_o.write_strobe_n;
    wire  we_fall = we_prev_r && !flash_o.write_strobe_n;

    a_erase_setup_code: assert property (
        we_fall && op_r == OP_ERASE && step_r == 3'd2 |->
        flash_o.dq_out == CMD_SETUP && flash_o.addr == ADDR_UNLOCK1)
        else $error("erase setup write wrong");

    a_erase_confirm_word: assert property (
        we_fall && op_r == OP_ERASE && step_r == 3'd5 |->
        flash_o.dq_out == CMD_CONFIRM && flash_o.addr == addr_r
        && $past(step_r, 20) != step_r)
        else $error("erase confirm write wrong");

    a_late_add_flag: assert property (
        late_set |=> late_r && status[ST_LATE_BIT])
        else $error("late added sector not flagged");

    a_hwreset_pin_drive: assert property (
        wr_lane && wr_hwrst && wdata[0] |=> !flash_o.reset_n ##0
        !status[ST_WINDOW_BIT])
        else $error("hardware reset not driven");

    a_hwreset_blocks_start: assert property (
        !flash_o.reset_n && st_r == ST_IDLE |=> st_r == ST_IDLE)
        else $error("operation started during hardware reset");

    a_ident_entry_code: assert property (
        we_fall && op_r == OP_IDENT && step_r == 3'd2 |->
        flash_o.dq_out == CMD_IDENT && flash_o.addr == ADDR_UNLOCK1)
        else $error("ident entry write wrong");

    a_secure_exit_zero: assert property (
        we_fall && op_r == OP_SEC_EXIT && step_r == 3'd3 |->
        flash_o.dq_out == CMD_ZERO
        ##1 !flash_o.write_strobe_n)
        else $error("secure exit final write wrong");

    a_buffer_commit: assert property (
        we_fall && op_r == OP_BUF_GO |->
        flash_o.dq_out == CMD_BUFGO && flash_o.addr == addr_r)
        else $error("buffer commit write wrong");

    a_abort_reset_code: assert property (
        we_fall && op_r == OP_ABORT_RST && step_r == 3'd2 |->
        flash_o.dq_out == CMD_RESET && flash_o.addr == ADDR_UNLOCK1)
        else $error("abort reset write wrong");

    a_bypass_prog_pair: assert property (
        we_fall && op_r == OP_BYP_PROG |->
        (step_r == 3'd0) ? flash_o.dq_out == CMD_PROGRAM
                         : flash_o.dq_out == data_r)
        else $error("bypass program write wrong");

    a_bypass_exit_pair: assert property (
        eng_done && op_r == OP_BYP_EXIT && step_r == 3'd0 |=>
        st_r == ST_ISSUE ##[1:20] we_fall && flash_o.dq_out == CMD_ZERO)
        else $error("bypass exit second write wrong");

endmodule
`default_nettype wire

// ===== bench/flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module flash_model
    import flash_host_pkg::*;
(
    input  wire flash_pins_t pins,
    output logic [15:0]      dq_in
);
    logic [21:0] wa[$];
    logic [15:0] wd[$];
    logic [21:0] a_lat = 22'h000000;
    logic [15:0] last  = 16'h0000;
    logic        tog   = 1'b0;
    wire  [15:0] rd_val = 16'hC3A0 | {9'h000, tog, 6'h00};

    ////////////////////////////////////////////////////////////////////////
    // Address held from strobe fall, word logged at strobe rise
    always @(negedge pins.write_strobe_n) begin
        a_lat = pins.addr;
    end
    always @(posedge pins.write_strobe_n) begin
        if (pins.chip_select_n === 1'b0) begin
            wa.push_back(a_lat);
            wd.push_back(pins.dq_out);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Toggle bit flips per read; released bus shows inverse of last value
    always @(posedge pins.output_enable_n) begin
        last = rd_val;
        tog = ~tog;
    end
    assign dq_in = (!pins.output_enable_n && !pins.chip_select_n) ? rd_val
                                                                  : ~last;
endmodule
`default_nettype wire

// ===== bench/flash_sector_erase_command_sequencer_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module flash_sector_erase_command_sequencer_tb_top;
    import flash_host_pkg::*;
    localparam int          ACC = 50;
    localparam logic [21:0] SA  = 22'h2A1234;
    localparam logic [15:0] PD  = 16'h5A3C;
    localparam logic [21:0] EA [6] = '{ADDR_UNLOCK1, ADDR_UNLOCK2,
        ADDR_UNLOCK1, ADDR_UNLOCK1, ADDR_UNLOCK2, SA};
    localparam logic [15:0] ED [6] = '{CMD_UNLOCK1, CMD_UNLOCK2, CMD_SETUP,
        CMD_UNLOCK1, CMD_UNLOCK2, CMD_CONFIRM};
    localparam logic [46:0] SEQ [12] = '{
        {OP_RESET, 4'h1, ADDR_ANY, CMD_RESET},
        {OP_IDENT, 4'h3, ADDR_UNLOCK1, CMD_IDENT},
        {OP_SEC_ENTER, 4'h3, ADDR_UNLOCK1, CMD_SECURE},
        {OP_SEC_EXIT, 4'h4, ADDR_ANY, CMD_ZERO},
        {OP_BUF_START, 4'h4, SA, PD},
        {OP_BUF_LOAD, 4'h1, SA, PD},
        {OP_BUF_GO, 4'h1, SA, CMD_BUFGO},
        {OP_ABORT_RST, 4'h3, ADDR_UNLOCK1, CMD_RESET},
        {OP_BYP_ENTER, 4'h3, ADDR_UNLOCK1, CMD_BYPASS},
        {OP_BYP_PROG, 4'h2, SA, PD},
        {OP_BYP_EXIT, 4'h2, ADDR_ANY, CMD_ZERO},
        {OP_PROGRAM, 4'h4, SA, PD}};
    logic        aclk, awready, wready, bvalid, arready, rvalid;
    logic        aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rv;
    logic [3:0]  wstrb = 4'h0;
    logic [1:0]  bresp, rresp, rsp;
    logic [15:0] dq_in;
    flash_pins_t flash_o;
    int          n_mismatch = 0, n_checks = 0;

    flash_host_ctrl #(.ACCEPT_CYC_P(ACC)) flash_host_ctrl_i (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .dq_in(dq_in),
        .flash_o(flash_o));
    flash_model flash_model_i (.pins(flash_o), .dq_in(dq_in));

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string w, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic wait_hi(ref logic s);
        int k;
        k = 0;
        do begin @(negedge aclk); k++; end while (s !== 1'b1 && k < 300);
        if (s !== 1'b1) chk("handshake", 1, 0);
        if (s !== 1'b1) end_sim();
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        wait_hi(awready);
        @(posedge aclk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        wait_hi(bvalid);
        r = bresp;
        @(posedge aclk);
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v,
                          output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        wait_hi(arready);
        @(posedge aclk);
        arvalid <= 1'b0;
        wait_hi(rvalid);
        v = rdata;
        r = rresp;
        @(posedge aclk);
        rready <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axi_wr(a, d, rsp);
        chk("bresp", RESP_OKAY, rsp);
    endtask
    task automatic run_op(input logic [4:0] op);
        int k;
        flash_model_i.wa.delete();
        flash_model_i.wd.delete();
        wr(REG_CTRL, {27'h0, op});
        k = 0;
        do begin axi_rd(REG_STATUS, rv, rsp); k++; end
            while (rv[ST_BUSY_BIT] !== 1'b0 && k < 100);
        chk("busy", 0, rv[ST_BUSY_BIT]);
    endtask
    task automatic lg(input int i, input logic [21:0] a, logic [15:0] d);
        chk("flash addr", a, flash_model_i.wa[i]);
        chk("flash data", d, flash_model_i.wd[i]);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_erase;
        wr(REG_ADDR, {10'h0, SA});
        run_op(OP_ERASE);
        chk("window", 1, rv[ST_WINDOW_BIT]);
        chk("erase count", 6, flash_model_i.wa.size());
        for (int i = 0; i < 6; i++) lg(i, EA[i], ED[i]);
        wr(REG_ADDR, 32'h001A8000);
        run_op(OP_ADD_SECT);
        lg(0, 22'h1A8000, CMD_CONFIRM);
        chk("late", 0, rv[ST_LATE_BIT]);
        run_op(OP_SUSPEND);
        lg(0, ADDR_ANY, CMD_SUSPEND);
        chk("window shut", 0, rv[ST_WINDOW_BIT]);
        run_op(OP_RESUME);
        lg(0, ADDR_ANY, CMD_CONFIRM);
        run_op(OP_ERASE);
        repeat (ACC + 10) @(posedge aclk);
        run_op(OP_ADD_SECT);
        chk("late set", 1, rv[ST_LATE_BIT]);
        wr(REG_STATUS, 32'h2);
        axi_rd(REG_STATUS, rv, rsp);
        chk("late clear", 0, rv[ST_LATE_BIT]);
        $display("t_erase done");
    endtask
    task automatic t_table;
        int n;
        wr(REG_DATA, {16'h0, PD});
        wr(REG_ADDR, {10'h0, SA});
        foreach (SEQ[j]) begin
            run_op(SEQ[j][46:42]);
            n = SEQ[j][41:38];
            chk("count", n, flash_model_i.wa.size());
            lg(n - 1, SEQ[j][37:16], SEQ[j][15:0]);
            if (n > 2) lg(0, ADDR_UNLOCK1, CMD_UNLOCK1);
        end
        $display("t_table done");
    endtask
    task automatic t_misc;
        logic t;
        axi_rd(REG_STATUS, rv, rsp);
        chk("status reset", 0, rv);
        chk("word mode", 1, flash_o.width_select_n);
        wr(REG_CTRL, 32'h00000011);
        axi_rd(REG_CTRL, rv, rsp);
        chk("bad op", 0, rv);
        run_op(OP_READ);
        axi_rd(REG_RDATA, rv, rsp);
        chk("read data", 16'hC3A0, rv[15:0] & 16'hFFBF);
        t = rv[6];
        run_op(OP_READ);
        axi_rd(REG_RDATA, rv, rsp);
        chk("toggle", !t, rv[6]);
        axi_rd(REG_STATUS, rv, rsp);
        chk("toggle seen", 1, rv[ST_TOGGLE_BIT]);
        wr(REG_HWRST, 32'h1);
        chk("reset pin", 0, flash_o.reset_n);
        wr(REG_HWRST, 32'h0);
        chk("reset off", 1, flash_o.reset_n);
        axi_wr(8'h40, 32'h1, rsp);
        chk("bresp bad", RESP_SLVERR, rsp);
        axi_rd(8'h40, rv, rsp);
        chk("rresp bad", RESP_SLVERR, rsp);
        $display("t_misc done");
    endtask

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_misc();
        t_erase();
        t_table();
        end_sim();
    end
endmodule
`default_nettype wire
